// file: asr_host.sv
// Host controller driving an asynchronous 32K x 8 static memory
`timescale 1ns/1ns
`include "asr_params.svh"
module asr_host #(
  parameter int ADDR_W = `ASR_ADDR_W,
  parameter int DATA_W = `ASR_DATA_W
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic retain_i,
  input wire logic [DATA_W-1:0] mem_data_i,
  output logic busy_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic retained_o,
  output logic mem_select_n_o,
  output logic mem_gate_n_o,
  output logic mem_strobe_n_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o
);

  // Cycle counts, rounded up, one cycle margin for output skew
  localparam logic [`ASR_CNT_W-1:0] WR_CYC = `ASR_CNT_W'(
    `ASR_CEIL_CYC(`ASR_SELECT_TO_WRITE_END_NS) + `ASR_MARGIN_CYC);
  localparam logic [`ASR_CNT_W-1:0] RD_CYC = `ASR_CNT_W'(
    `ASR_CEIL_CYC(`ASR_SELECT_ACCESS_NS) + `ASR_MARGIN_CYC);
  localparam logic [`ASR_CNT_W-1:0] TURN_CYC = `ASR_CNT_W'(
    `ASR_CEIL_CYC(`ASR_SELECT_TURNOFF_NS) + `ASR_MARGIN_CYC);
  localparam logic [`ASR_CNT_W-1:0] RECOVER_CYC = `ASR_CNT_W'(
    `ASR_CEIL_CYC(`ASR_RETENTION_RECOVERY_NS) + `ASR_MARGIN_CYC);

  asr_pkg::asr_state_t state;
  logic [`ASR_CNT_W-1:0] cnt;
  logic cnt_zero;

  assign cnt_zero = (cnt == `ASR_CNT_W'(0));

  // Sequencer; one access at a time, no overlap of read and write
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= asr_pkg::ASR_IDLE;
      cnt <= `ASR_CNT_W'(0);
    end
    else
    begin
      unique case (state)
        asr_pkg::ASR_IDLE:
        begin
          if (!cnt_zero)
            cnt <= cnt - `ASR_CNT_W'(1);
          else if (retain_i)
            state <= asr_pkg::ASR_RETAIN;
          else if (req_i && req_write_i)
          begin
            state <= asr_pkg::ASR_WR;
            cnt <= WR_CYC - `ASR_CNT_W'(1);
          end
          else if (req_i)
          begin
            state <= asr_pkg::ASR_RD;
            cnt <= RD_CYC - `ASR_CNT_W'(1);
          end
        end
        asr_pkg::ASR_WR:
        begin
          if (cnt_zero)
            state <= asr_pkg::ASR_WR_END;
          else
            cnt <= cnt - `ASR_CNT_W'(1);
        end
        asr_pkg::ASR_WR_END:
          state <= asr_pkg::ASR_IDLE;
        asr_pkg::ASR_RD:
        begin
          if (cnt_zero)
          begin
            state <= asr_pkg::ASR_TURN;
            cnt <= TURN_CYC - `ASR_CNT_W'(1);
          end
          else
            cnt <= cnt - `ASR_CNT_W'(1);
        end
        asr_pkg::ASR_TURN:
        begin
          if (cnt_zero)
            state <= asr_pkg::ASR_IDLE;
          else
            cnt <= cnt - `ASR_CNT_W'(1);
        end
        asr_pkg::ASR_RETAIN:
        begin
          if (!retain_i)
          begin
            state <= asr_pkg::ASR_IDLE;
            cnt <= RECOVER_CYC;
          end
        end
        default:
          state <= asr_pkg::ASR_IDLE;
      endcase
    end
  end

  // Memory strobes; write ended by select and strobe rising together
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mem_select_n_o <= 1'b1;
      mem_strobe_n_o <= 1'b1;
      mem_gate_n_o <= 1'b1;
    end
    else
    begin
      // Start strobes in the same edge the state is entered
      mem_select_n_o <= 1'b1;
      mem_strobe_n_o <= 1'b1;
      mem_gate_n_o <= 1'b1;
      if (state == asr_pkg::ASR_IDLE && cnt_zero && !retain_i && req_i)
      begin
        mem_select_n_o <= 1'b0;
        mem_strobe_n_o <= !req_write_i;
        mem_gate_n_o <= req_write_i;
      end
      else if (state == asr_pkg::ASR_WR && !cnt_zero)
      begin
        mem_select_n_o <= 1'b0;
        mem_strobe_n_o <= 1'b0;
      end
      else if (state == asr_pkg::ASR_RD && !cnt_zero)
      begin
        mem_select_n_o <= 1'b0;
        mem_gate_n_o <= 1'b0;
      end
    end
  end

  // Address and write data held through strobe rise, zero hold needed
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mem_addr_o <= '0;
      mem_data_o <= '0;
      mem_data_oe_o <= 1'b0;
    end
    else if (state == asr_pkg::ASR_IDLE && cnt_zero && !retain_i && req_i)
    begin
      mem_addr_o <= req_addr_i;
      mem_data_o <= req_wdata_i;
      mem_data_oe_o <= req_write_i;
    end
    else if (state == asr_pkg::ASR_WR_END)
      mem_data_oe_o <= 1'b0;
  end

  // Read capture at the last active cycle, after every access limit
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (state == asr_pkg::ASR_RD && cnt_zero)
      begin
        rdata_o <= mem_data_i;
        done_o <= 1'b1;
      end
      else if (state == asr_pkg::ASR_WR_END)
        done_o <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_o <= 1'b1;
      retained_o <= 1'b0;
    end
    else
    begin
      busy_o <= !(state == asr_pkg::ASR_IDLE && cnt_zero && !req_i
        && !retain_i);
      retained_o <= (state == asr_pkg::ASR_RETAIN);
    end
  end
endmodule

// file: asr_params.svh
// Timing constants and field widths of the static memory host controller
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
`define ASR_CLK_NS 100
`define ASR_ADDR_W 15
`define ASR_DATA_W 8
`define ASR_WRITE_PULSE_MIN_NS 50
`define ASR_SELECT_TO_WRITE_END_NS 60
`define ASR_WRITE_ADDR_SETUP_NS 60
`define ASR_WRITE_DATA_SETUP_NS 30
`define ASR_WRITE_CYCLE_MIN_NS 70
`define ASR_STROBE_TURNOFF_NS 25
`define ASR_ADDR_ACCESS_NS 70
`define ASR_SELECT_ACCESS_NS 70
`define ASR_GATE_ACCESS_NS 35
`define ASR_GATE_TURNOFF_NS 25
`define ASR_SELECT_TURNOFF_NS 25
`define ASR_RETENTION_RECOVERY_NS 70
`define ASR_CEIL_CYC(ns) (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MARGIN_CYC 1
`define ASR_CNT_W 4
`endif

// file: asr_pkg.sv
// Types shared by the static memory host controller
package asr_pkg;
  typedef enum logic [5:0] {
    ASR_IDLE = 6'h01,
    ASR_RD = 6'h02,
    ASR_WR = 6'h04,
    ASR_WR_END = 6'h08,
    ASR_TURN = 6'h10,
    ASR_RETAIN = 6'h20
  } asr_state_t;
endpackage

// file: asr_host_properties.sv
// Port assertions for the static memory host controller
`timescale 1ns/1ns
`include "asr_params.svh"
module asr_host_properties #(
  parameter int ADDR_W = `ASR_ADDR_W,
  parameter int DATA_W = `ASR_DATA_W
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic retain_i,
  input wire logic done_o,
  input wire logic retained_o,
  input wire logic mem_select_n_o,
  input wire logic mem_gate_n_o,
  input wire logic mem_strobe_n_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [DATA_W-1:0] mem_data_o,
  input wire logic mem_data_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Openings of the write and read strobe phases
  sequence wr_go;
    $fell(mem_strobe_n_o);
  endsequence
  sequence rd_go;
    $fell(mem_gate_n_o);
  endsequence
  a_strobe_in_select: assert property (
    !mem_strobe_n_o |-> !mem_select_n_o) else $error("strobe unselected");
  a_write_shape: assert property (
    wr_go |-> ##1 !mem_strobe_n_o ##1
    ($rose(mem_select_n_o) && $rose(mem_strobe_n_o) && mem_data_oe_o)
    ##1 (done_o && !mem_data_oe_o)) else $error("write shape");
  a_read_shape: assert property (rd_go |-> mem_strobe_n_o ##1
    !mem_gate_n_o ##1 ($rose(mem_gate_n_o) && done_o)) else $error("read");
  a_host_quiet: assert property (mem_data_oe_o |-> mem_gate_n_o &&
    $past(mem_gate_n_o, 2)) else $error("bus clash");
  a_addr_steady: assert property (!mem_select_n_o &&
    !$past(mem_select_n_o) |-> $stable(mem_addr_o)) else $error("addr");
  a_data_setup: assert property ($rose(mem_strobe_n_o) |->
    mem_data_o == $past(mem_data_o, 2)) else $error("data setup");
  a_retain_off: assert property (
    retained_o |-> mem_select_n_o) else $error("retain select");
  a_recover_gap: assert property (
    $fell(retain_i) |-> mem_select_n_o [*3]) else $error("recovery");
endmodule
bind asr_host asr_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_props (.core_clk_i, .reset_i, .retain_i,
  .done_o, .retained_o, .mem_select_n_o, .mem_gate_n_o, .mem_strobe_n_o,
  .mem_addr_o, .mem_data_o, .mem_data_oe_o);

// file: asr_mem_model.sv
// Behavioural model of the asynchronous static memory
`timescale 1ns/1ns
module asr_mem_model (
  input wire logic sel_n_i,
  input wire logic gate_n_i,
  input wire logic strobe_n_i,
  input wire logic [14:0] addr_i,
  input wire logic host_oe_i,
  input wire logic [7:0] host_d_i,
  output logic [7:0] bus_o
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  wire wr = !sel_n_i && !strobe_n_i;
  wire act = !sel_n_i && !gate_n_i && strobe_n_i;
  wire en;
  // Slow turn-on, quick release, so a late sample sees junk
  assign #(70, 25) en = act;
  assign bus_o = host_oe_i ? host_d_i : en ? mem[addr_i] : ~last;
  // Store at write end; remember driven value for release pattern
  always @(negedge wr) mem[addr_i] = bus_o;
  always @(posedge en) last = mem[addr_i];
endmodule

// file: tb_top.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i = 1'b0;
  logic req_write_i = 1'b0;
  logic retain_i = 1'b0;
  logic [14:0] req_addr_i = 15'h0000;
  logic [7:0] req_wdata_i = 8'h00;
  logic busy_o, done_o, retained_o, sel_n, gate_n, strobe_n, oe;
  logic [7:0] rdata_o, mem_d, host_d;
  logic [14:0] addr;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  asr_host dut (.core_clk_i, .reset_i, .req_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .retain_i, .mem_data_i(mem_d), .busy_o, .done_o, .rdata_o,
    .retained_o, .mem_select_n_o(sel_n), .mem_gate_n_o(gate_n),
    .mem_strobe_n_o(strobe_n), .mem_addr_o(addr), .mem_data_o(host_d),
    .mem_data_oe_o(oe));
  asr_mem_model u_mem (.sel_n_i(sel_n), .gate_n_i(gate_n),
    .strobe_n_i(strobe_n), .addr_i(addr), .host_oe_i(oe), .host_d_i(host_d),
    .bus_o(mem_d));
  // Clock and hang guard
  initial forever #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task step();
    @(posedge core_clk_i);
    #10;
  endtask
  // One access, request held until the done pulse
  task automatic access(input logic w, input logic [14:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    step();
    req_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    do
    begin
      step();
      n++;
    end while (done_o !== 1'b1 && n < 30);
    req_i = 1'b0;
    `CHK((n < 30), 1'b1)
  endtask
  // Boundary and alternating-bit addresses, writes then reads back to back
  task automatic t_write_read();
    logic [14:0] a [3] = '{15'h0000, 15'h7FFF, 15'h2AAA};
    logic [7:0] d [3] = '{8'hA5, 8'h5A, 8'hFF};
    for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i]);
    for (int i = 0; i < 3; i++)
    begin
      access(1'b0, a[i], 8'h00);
      `CHK(rdata_o, d[i])
    end
    $display("test write_read done");
  endtask
  // Retention holds select high; contents survive the recovery
  task automatic t_retain();
    // Two turnaround cycles, one to enter retention, one for the flag
    retain_i = 1'b1;
    repeat (5) step();
    `CHK(retained_o, 1'b1)
    `CHK(sel_n, 1'b1)
    `CHK(busy_o, 1'b1)
    retain_i = 1'b0;
    access(1'b0, 15'h7FFF, 8'h00);
    `CHK(rdata_o, 8'h5A)
    $display("test retain done");
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    #10;
    reset_i = 1'b0;
    t_write_read();
    t_retain();
    finish_test();
  end
endmodule
